// ---- ctsr_cfg.svh ----
`ifndef CTSR_CFG_SVH
`define CTSR_CFG_SVH
`define CTSR_OFF_CTRL      8'h04
`define CTSR_OFF_CTRL_SET  8'h08
`define CTSR_OFF_CTRL_CLR  8'h0c
`define CTSR_OFF_STAT      8'h40
`define CTSR_OFF_STAT_RC   8'h44
`define CTSR_OFF_COUNT     8'h48
`define CTSR_OFF_ALIGN     8'h4c
`define CTSR_OFF_WB_LO     8'h88
`define CTSR_OFF_WB_HI     8'h8c
`define CTSR_OFF_MASK      8'h90
`define CTSR_CTRL_MASK     32'h0ef8_3e7f
`define CTSR_STAT_W1C      32'h00f8_3e7e
`define CTSR_IMASK_MASK    32'h00f8_3e56
`define CTSR_RDERR_MASK    5'h03
`define CTSR_FAULT_ALL     5'h1f
`define CTSR_RESP_OKAY     2'b00
`define CTSR_RESP_SLVERR   2'b10
`define CTSR_B_RUN         0
`define CTSR_DFLT          23:19
`define CTSR_RFLT          13:9
`define CTSR_B_IDLE        6
`define CTSR_B_BADLEN      5
`define CTSR_B_BADSIG      4
`define CTSR_B_ALIGN       3
`define CTSR_B_DONE        2
`define CTSR_B_STOP        1
`define CTSR_STAT_KEEP     32'h0000_0008
`endif

// ---- ctsr_channel_regs.sv ----
// The AXI4-Lite slave port was chosen for this implementation.
`include "ctsr_cfg.svh"
`default_nettype none
// What this block does
// - Writes at set alias set control bits; at clear alias clear them.
// - Descriptor fault field, write-one-clear, zeroed when run is set.
// - Bus-read fault field, only bits 1:0 used, zeroed when run set.
// - Halted-idle flag set when engine idles after run cleared, if enabled.
// - Bad-length flag logged when enabled; zeroed on run set.
// - Bad-signature flag logged and engine halted when enabled.
// - Alignment-conflict flag set on misaligned descriptor, write-one-clear.
// - Descriptor-done flag logged on completed marked descriptor when enabled.
// - Stop-marker flag logged, gated by the bad-signature enable.
// - Busy bit reads one while the engine works.
// - Read-clear alias returns status and clears bits 23 to 1.
// - 32-bit completed descriptor count, incremented per finished descriptor.
// - Count zeroed on each rising edge of run.
// - Address alignment reported read-only from parameters.
// - Length granularity reported read-only from parameters.
// - Address bit count reported read-only in low byte.
// - 64-bit writeback address as two read-write words, reset zero.
// - Per-bit interrupt masks for descriptor and bus-read faults.
// - Mask bits for halted-idle and bad-signature flags.
// - Mask bits for descriptor-done and stop-marker flags.
// - Run starts engine; clearing run lets current descriptor finish.
// - Log only when enabled, except alignment conflict; interrupt only when also masked.
// - Faults logged and engine halted only when enable field is all ones.
module ctsr_channel_regs #(
    parameter logic [7:0] ADDR_ALIGN  = 8'h01,
    parameter logic [7:0] LEN_GRAN    = 8'h01,
    parameter logic [7:0] ADDR_BITS   = 8'h40
) (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Engine side
    input  wire ctsr_pkg::ctsr_events_s eng_events,
    input  wire logic                  eng_desc_active,
    output logic                       eng_busy,
    output logic                       eng_halt,
    output logic                       irq_pending,
    output logic [31:0]                ctrl_word,
    output logic [63:0]                poll_wb_addr
);
    import ctsr_pkg::*;

    function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) res[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return res;
    endfunction

    function automatic logic addr_known(input logic [7:0] a);
        case (a)
            `CTSR_OFF_CTRL, `CTSR_OFF_CTRL_SET, `CTSR_OFF_CTRL_CLR, `CTSR_OFF_STAT,
            `CTSR_OFF_STAT_RC, `CTSR_OFF_COUNT, `CTSR_OFF_ALIGN, `CTSR_OFF_WB_LO,
            `CTSR_OFF_WB_HI, `CTSR_OFF_MASK: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Bus handshake state
    logic        aw_held_r, aw_held_nxt;
    logic        w_held_r, w_held_nxt;
    logic [7:0]  aw_addr_r, aw_addr_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0]  w_strb_r, w_strb_nxt;
    logic        bvalid_r, bvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [1:0]  rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    // Register state
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [31:0] stat_r, stat_nxt;
    logic [31:0] count_r, count_nxt;
    logic [31:0] wb_lo_r, wb_lo_nxt;
    logic [31:0] wb_hi_r, wb_hi_nxt;
    logic [31:0] imask_r, imask_nxt;
    logic        run_d_r;
    logic        halt_r, halt_nxt;
    logic        irq_r, irq_nxt;
    logic        busy_q_r, awready_r, wready_r, arready_r, stopped_r, stopped_nxt;

    logic        do_write, do_read, run_rise, busy_w, went_idle_w;
    logic [31:0] wval, set_bits, rd_word;
    ctsr_status_s st_view;

    ctsr_engine_tracker u_tracker (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .run         (ctrl_r[`CTSR_B_RUN] && !stopped_r),
        .halt_req    (halt_r),
        .desc_active (eng_desc_active),
        .busy        (busy_w),
        .went_idle   (went_idle_w)
    );

    assign do_write = (aw_held_r && w_held_r && !bvalid_r);
    assign do_read  = (s_axi_arvalid && !rvalid_r);
    assign run_rise = ctrl_r[`CTSR_B_RUN] && !run_d_r;
    assign wval     = byte_merge(32'h0, w_data_r, w_strb_r);

    // Hardware set terms, each gated by a logging enable except alignment conflict
    always_comb begin
        set_bits = 32'h0;
        if (ctrl_r[`CTSR_DFLT] == `CTSR_FAULT_ALL)
            set_bits[`CTSR_DFLT] = eng_events.desc_fault;
        if (ctrl_r[`CTSR_RFLT] == `CTSR_FAULT_ALL)
            set_bits[`CTSR_RFLT] = eng_events.read_fault & `CTSR_RDERR_MASK;
        set_bits[`CTSR_B_IDLE] = ctrl_r[`CTSR_B_IDLE] && went_idle_w
                                 && !ctrl_r[`CTSR_B_RUN];
        set_bits[`CTSR_B_BADLEN] = ctrl_r[`CTSR_B_BADLEN] && eng_events.bad_length;
        set_bits[`CTSR_B_BADSIG] = ctrl_r[`CTSR_B_BADSIG] && eng_events.bad_signature;
        set_bits[`CTSR_B_ALIGN] = eng_events.align_conflict;
        set_bits[`CTSR_B_DONE] = ctrl_r[`CTSR_B_DONE] && eng_events.desc_finished
                                 && eng_events.desc_complete_marker;
        set_bits[`CTSR_B_STOP] = ctrl_r[`CTSR_B_BADSIG] && eng_events.desc_finished
                                 && eng_events.desc_stop_marker;
    end

    always_comb begin
        st_view       = ctsr_status_s'(stat_r);
        st_view.busy  = busy_w;
        rd_word = 32'h0;
        case (s_axi_araddr)
            `CTSR_OFF_CTRL, `CTSR_OFF_CTRL_SET, `CTSR_OFF_CTRL_CLR: rd_word = ctrl_r;
            `CTSR_OFF_STAT, `CTSR_OFF_STAT_RC: rd_word = 32'(st_view);
            `CTSR_OFF_COUNT: rd_word = count_r;
            `CTSR_OFF_ALIGN: rd_word = {8'h0, ADDR_ALIGN, LEN_GRAN, ADDR_BITS};
            `CTSR_OFF_WB_LO: rd_word = wb_lo_r;
            `CTSR_OFF_WB_HI: rd_word = wb_hi_r;
            `CTSR_OFF_MASK:  rd_word = imask_r;
            default:         rd_word = 32'h0;
        endcase
    end

    // Bus channels
    always_comb begin
        aw_held_nxt = aw_held_r;
        w_held_nxt  = w_held_r;
        aw_addr_nxt = aw_addr_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rresp_nxt   = rresp_r;
        rdata_nxt   = rdata_r;
        if (s_axi_awvalid && !aw_held_r) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_r) begin
            w_held_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (do_write) begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            bresp_nxt   = addr_known(aw_addr_r) ? `CTSR_RESP_OKAY : `CTSR_RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (do_read) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = rd_word;
            rresp_nxt  = addr_known(s_axi_araddr) ? `CTSR_RESP_OKAY : `CTSR_RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    // Register updates
    always_comb begin
        ctrl_nxt  = ctrl_r;
        stat_nxt  = stat_r;
        count_nxt = count_r;
        wb_lo_nxt = wb_lo_r;
        wb_hi_nxt = wb_hi_r;
        imask_nxt = imask_r;
        if (do_write) begin
            case (aw_addr_r)
                `CTSR_OFF_CTRL:
                    ctrl_nxt = byte_merge(ctrl_r, w_data_r, w_strb_r) & `CTSR_CTRL_MASK;
                `CTSR_OFF_CTRL_SET: ctrl_nxt = (ctrl_r | wval) & `CTSR_CTRL_MASK;
                `CTSR_OFF_CTRL_CLR: ctrl_nxt = ctrl_r & ~wval;
                `CTSR_OFF_STAT: stat_nxt = stat_r & ~(wval & `CTSR_STAT_W1C);
                `CTSR_OFF_WB_LO: wb_lo_nxt = byte_merge(wb_lo_r, w_data_r, w_strb_r);
                `CTSR_OFF_WB_HI: wb_hi_nxt = byte_merge(wb_hi_r, w_data_r, w_strb_r);
                `CTSR_OFF_MASK:
                    imask_nxt = byte_merge(imask_r, w_data_r, w_strb_r) & `CTSR_IMASK_MASK;
                default: ;
            endcase
        end
        if (do_read && s_axi_araddr == `CTSR_OFF_STAT_RC)
            stat_nxt = stat_nxt & ~`CTSR_STAT_W1C;
        if (run_rise) begin
            stat_nxt  = stat_nxt & `CTSR_STAT_W1C & `CTSR_STAT_KEEP;
            count_nxt = 32'h0;
        end else if (eng_events.desc_finished) begin
            count_nxt = count_r + 32'h1;
        end
        stat_nxt = stat_nxt | set_bits;
    end

    // Halt on logged signature or fault; engine stays down until run drops
    always_comb begin
        halt_nxt = set_bits[`CTSR_B_BADSIG] || (|set_bits[`CTSR_DFLT])
                   || (|set_bits[`CTSR_RFLT]);
        stopped_nxt = halt_r || (stopped_r && ctrl_r[`CTSR_B_RUN]);
        irq_nxt  = |(stat_r & imask_r);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            aw_addr_r <= 8'h0;
            w_data_r  <= 32'h0;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `CTSR_RESP_OKAY;
            rvalid_r  <= 1'b0;
            rresp_r   <= `CTSR_RESP_OKAY;
            rdata_r   <= 32'h0;
            ctrl_r    <= 32'h0;
            stat_r    <= 32'h0;
            count_r   <= 32'h0;
            wb_lo_r   <= 32'h0;
            wb_hi_r   <= 32'h0;
            imask_r   <= 32'h0;
            run_d_r   <= 1'b0;
            halt_r    <= 1'b0;
            irq_r     <= 1'b0;
            busy_q_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            arready_r <= 1'b1;
            stopped_r <= 1'b0;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rresp_r   <= rresp_nxt;
            rdata_r   <= rdata_nxt;
            ctrl_r    <= ctrl_nxt;
            stat_r    <= stat_nxt;
            count_r   <= count_nxt;
            wb_lo_r   <= wb_lo_nxt;
            wb_hi_r   <= wb_hi_nxt;
            imask_r   <= imask_nxt;
            run_d_r   <= ctrl_r[`CTSR_B_RUN];
            halt_r    <= halt_nxt;
            irq_r     <= irq_nxt;
            busy_q_r  <= busy_w;
            awready_r <= !aw_held_nxt;
            wready_r  <= !w_held_nxt;
            arready_r <= !rvalid_nxt;
            stopped_r <= stopped_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;
    assign eng_busy      = busy_q_r;
    assign eng_halt      = halt_r;
    assign irq_pending   = irq_r;
    assign ctrl_word     = ctrl_r;
    assign poll_wb_addr  = {wb_hi_r, wb_lo_r};

    property p_set_alias;
        @(posedge aclk) disable iff (!aresetn)
        do_write && aw_addr_r == `CTSR_OFF_CTRL_SET && wval[0] |=> ctrl_r[0];
    endproperty
    a_set_alias: assert property (p_set_alias) else $error("set alias lost run");

    property p_clr_alias;
        @(posedge aclk) disable iff (!aresetn)
        do_write && aw_addr_r == `CTSR_OFF_CTRL_CLR && wval[0] |=> !ctrl_r[0];
    endproperty
    a_clr_alias: assert property (p_clr_alias) else $error("clear alias kept run");

    property p_run_zero;
        @(posedge aclk) disable iff (!aresetn)
        run_rise && !eng_events.desc_finished |=> count_r == 32'h0;
    endproperty
    a_run_zero: assert property (p_run_zero) else $error("count not zeroed");

    property p_count_inc;
        @(posedge aclk) disable iff (!aresetn)
        eng_events.desc_finished && !run_rise |=> count_r == $past(count_r) + 32'h1;
    endproperty
    a_count_inc: assert property (p_count_inc) else $error("count not incremented");

    property p_rc_clear;
        @(posedge aclk) disable iff (!aresetn)
        do_read && s_axi_araddr == `CTSR_OFF_STAT_RC && set_bits == 32'h0 && !do_write
        |=> (stat_r & `CTSR_STAT_W1C) == 32'h0;
    endproperty
    a_rc_clear: assert property (p_rc_clear) else $error("read clear failed");

    property p_set_wins;
        @(posedge aclk) disable iff (!aresetn)
        set_bits[3] |=> stat_r[3];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost");

    property p_rd_fault_hi;
        @(posedge aclk) disable iff (!aresetn) stat_r[13:11] == 3'h0;
    endproperty
    a_rd_fault_hi: assert property (p_rd_fault_hi) else $error("reserved fault bits set");

    property p_no_log;
        @(posedge aclk) disable iff (!aresetn)
        !ctrl_r[2] && !stat_r[2] && !run_rise |=> !stat_r[2];
    endproperty
    a_no_log: assert property (p_no_log) else $error("logged while disabled");

    property p_irq;
        @(posedge aclk) disable iff (!aresetn)
        (stat_r[4] && imask_r[4]) |=> irq_pending;
    endproperty
    a_irq: assert property (p_irq) else $error("mask did not raise irq");

    c_write: cover property (@(posedge aclk) do_write);
    c_rc:    cover property (@(posedge aclk) do_read && s_axi_araddr == `CTSR_OFF_STAT_RC);
    c_run:   cover property (@(posedge aclk) run_rise);
    c_halt:  cover property (@(posedge aclk) eng_halt);
endmodule // ctsr_channel_regs
`default_nettype wire

// ---- ctsr_engine_tracker.sv ----
`include "ctsr_cfg.svh"
`default_nettype none
// Tracks the engine: starts on run, drains the current descriptor on stop
module ctsr_engine_tracker (
    // Clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // Control
    input  wire logic          run,
    input  wire logic          halt_req,
    input  wire logic          desc_active,
    // State
    output logic               busy,
    output logic               went_idle
);
    import ctsr_pkg::*;
    ctsr_eng_e state_r, state_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ENG_IDLE:  if (run && !halt_req) state_nxt = ENG_RUN;
            ENG_RUN:   if (halt_req) state_nxt = ENG_IDLE;
                       else if (!run) state_nxt = ENG_DRAIN;
            ENG_DRAIN: if (!desc_active || halt_req) state_nxt = ENG_IDLE;
            default:   state_nxt = ENG_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) state_r <= ENG_IDLE;
        else state_r <= state_nxt;
    end

    assign busy      = (state_r != ENG_IDLE);
    assign went_idle = (state_r != ENG_IDLE) && (state_nxt == ENG_IDLE);
endmodule // ctsr_engine_tracker
`default_nettype wire

// ---- ctsr_pkg.sv ----
`default_nettype none
package ctsr_pkg;
    // Status word layout, bit 31 down to bit 0
    typedef struct packed {
        logic [7:0] rsvd_hi;
        logic [4:0] desc_fault;
        logic [4:0] rsvd_mid;
        logic [4:0] read_fault;
        logic [1:0] rsvd_lo;
        logic       halted_idle;
        logic       bad_length;
        logic       bad_signature;
        logic       align_conflict;
        logic       descriptor_done;
        logic       stop_marker_done;
        logic       busy;
    } ctsr_status_s;

    // Engine event strobes, one cycle each
    typedef struct packed {
        logic [4:0] desc_fault;
        logic [4:0] read_fault;
        logic       bad_length;
        logic       bad_signature;
        logic       align_conflict;
        logic       desc_finished;
        logic       desc_complete_marker;
        logic       desc_stop_marker;
    } ctsr_events_s;

    typedef enum logic [1:0] {ENG_IDLE, ENG_RUN, ENG_DRAIN} ctsr_eng_e;
endpackage : ctsr_pkg
`default_nettype wire

// ---- tb_top.sv ----
`include "ctsr_cfg.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ctsr_pkg::*;

    logic          aclk;
    logic          aresetn;
    logic [7:0]    s_axi_awaddr;
    logic [7:0]    s_axi_araddr;
    logic          s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic          s_axi_bvalid, s_axi_bready;
    logic          s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0]   s_axi_wdata;
    logic [31:0]   s_axi_rdata;
    logic [3:0]    s_axi_wstrb;
    logic [1:0]    s_axi_bresp, s_axi_rresp;
    ctsr_events_s  eng_events;
    logic          eng_desc_active, eng_busy, eng_halt, irq_pending;
    logic [31:0]   ctrl_word;
    logic [63:0]   poll_wb_addr;
    int            errors, samples_checked, cycles, halts;
    logic [1:0]    resp;
    logic [31:0]   data;

    ctsr_channel_regs #(.ADDR_ALIGN(8'h01), .LEN_GRAN(8'h01), .ADDR_BITS(8'h40)) dut_u (
        .aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .eng_events, .eng_desc_active, .eng_busy, .eng_halt,
        .irq_pending, .ctrl_word, .poll_wb_addr
    );

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Hang guard, well above the two hundred or so cycles the sequence needs
    always @(posedge aclk) begin
        cycles++;
        if (eng_halt === 1'b1) halts++;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Address and data offered together, each released on its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (!w_done && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                w_done = 1'b1;
            end
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a);
        logic ar_done;
        ar_done = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (!ar_done && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                ar_done = 1'b1;
            end
            if (s_axi_rvalid) begin
                data = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        rd(a);
        chk(data & m, exp);
    endtask

    // Flags: bad_length, bad_signature, align, finished, complete, stop
    task automatic pulse(input logic [4:0] df, input logic [4:0] rf, input logic [5:0] f);
        @(posedge aclk);
        eng_events <= ctsr_events_s'({df, rf, f});
        @(posedge aclk);
        eng_events <= '0;
        repeat (2) @(posedge aclk);
    endtask

    localparam logic [31:0] ALL = 32'hffff_ffff;
    localparam logic [31:0] NB  = 32'hffff_fffe;

    initial begin
        aresetn = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        eng_events = '0;
        eng_desc_active = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(`CTSR_OFF_STAT, ALL, 32'h0);
        rdc(`CTSR_OFF_COUNT, ALL, 32'h0);
        rdc(`CTSR_OFF_ALIGN, ALL, 32'h0001_0140);
        rdc(`CTSR_OFF_WB_LO, ALL, 32'h0);
        rdc(`CTSR_OFF_WB_HI, ALL, 32'h0);
        rdc(`CTSR_OFF_MASK, ALL, 32'h0);
        rdc(8'h50, ALL, 32'h0);
        chk({30'h0, resp}, {30'h0, `CTSR_RESP_SLVERR});
        wr(8'ha0, ALL);
        chk({30'h0, resp}, {30'h0, `CTSR_RESP_SLVERR});
        // Partial strobe must touch only byte 0
        wr(`CTSR_OFF_WB_LO, 32'h1234_5678);
        chk({30'h0, resp}, {30'h0, `CTSR_RESP_OKAY});
        wr(`CTSR_OFF_WB_HI, 32'h9abc_def0);
        wr(`CTSR_OFF_WB_LO, ALL, 4'h1);
        rdc(`CTSR_OFF_WB_LO, ALL, 32'h1234_56ff);
        chk(poll_wb_addr[63:32], 32'h9abc_def0);
        chk(poll_wb_addr[31:0], 32'h1234_56ff);
        wr(`CTSR_OFF_CTRL_SET, 32'h00f8_3e7f);
        chk(ctrl_word, 32'h00f8_3e7f);
        rdc(`CTSR_OFF_CTRL, ALL, 32'h00f8_3e7f);
        rdc(`CTSR_OFF_STAT, ALL, 32'h1);
        chk({31'h0, eng_busy}, 32'h1);
        // Finished descriptors first, before faults halt the engine
        pulse(5'h00, 5'h00, 6'h06);
        pulse(5'h00, 5'h00, 6'h05);
        pulse(5'h00, 5'h00, 6'h20);
        pulse(5'h00, 5'h00, 6'h10);
        rdc(`CTSR_OFF_STAT, 32'h1, 32'h0);
        chk({31'h0, eng_busy}, 32'h0);
        chk(halts, 32'h1);
        pulse(5'h00, 5'h00, 6'h08);
        pulse(5'h05, 5'h1f, 6'h00);
        chk(halts, 32'h2);
        rdc(`CTSR_OFF_STAT, NB, 32'h0028_063e);
        rdc(`CTSR_OFF_COUNT, ALL, 32'h2);
        wr(`CTSR_OFF_MASK, ALL);
        rdc(`CTSR_OFF_MASK, ALL, `CTSR_IMASK_MASK);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq_pending}, 32'h1);
        wr(`CTSR_OFF_MASK, 32'h0);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq_pending}, 32'h0);
        wr(`CTSR_OFF_MASK, 32'h4);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq_pending}, 32'h1);
        wr(`CTSR_OFF_STAT, 32'h8);
        rdc(`CTSR_OFF_STAT, NB, 32'h0028_0636);
        rdc(`CTSR_OFF_STAT_RC, NB, 32'h0028_0636);
        rdc(`CTSR_OFF_STAT, NB, 32'h0);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq_pending}, 32'h0);
        wr(`CTSR_OFF_CTRL_CLR, 32'h0080_0000);
        chk(ctrl_word, 32'h0078_3e7f);
        pulse(5'h1f, 5'h00, 6'h00);
        chk(halts, 32'h2);
        rdc(`CTSR_OFF_STAT, NB, 32'h0);
        wr(`CTSR_OFF_CTRL_CLR, 32'h1);
        wr(`CTSR_OFF_CTRL_SET, 32'h1);
        rdc(`CTSR_OFF_STAT, ALL, 32'h1);
        rdc(`CTSR_OFF_COUNT, ALL, 32'h0);
        pulse(5'h00, 5'h00, 6'h06);
        rdc(`CTSR_OFF_COUNT, ALL, 32'h1);
        // Stop requested mid-descriptor: engine must stay busy until it ends
        eng_desc_active <= 1'b1;
        wr(`CTSR_OFF_CTRL_CLR, 32'h1);
        rdc(`CTSR_OFF_STAT, ALL, 32'h5);
        eng_desc_active <= 1'b0;
        repeat (4) @(posedge aclk);
        rdc(`CTSR_OFF_STAT, ALL, 32'h44);
        chk({31'h0, eng_busy}, 32'h0);
        wr(`CTSR_OFF_STAT, 32'h40);
        rdc(`CTSR_OFF_STAT, ALL, 32'h4);
        // Direct control word write, byte 1 only
        wr(`CTSR_OFF_CTRL, 32'h0, 4'h2);
        chk(ctrl_word, 32'h0078_007e);
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
